// ==== hdl/mode_sequencer.v ====
`timescale 1ns/10ps
`default_nettype none
`include "mode_seq_regs.vh"
// Operation
// R1 - below supply-good, hold all internal functions off in lockout
// R2 - lockout keeps gate drive off whatever the command input does
// R3 - after supply good, enter normal mode on command going high; the code enters on a high command level, with no rising edge needed
// R4 - supply fail from any active mode disables drive, returns to lockout
// R5 - in normal mode gate drive follows command input
// R6 - in normal mode enable sense output while transistor is on
// R7 - command low for standby timeout enters standby
// R8 - standby keeps drive off and current sense off
// R9 - further low for sleep timeout moves standby to sleep
// R10 - sleep keeps drive off and shuts remaining functions
// R11 - first rising command edge wakes to normal within bounded delay
// R12 - controller expects standby or sleep when it stops pulsing
// R13 - controller tolerates wake delay after leaving lockout
// R14 - any high command level clears idle timers
// R15 - sleep timeout starts only after standby entry
module mode_sequencer
#(
   parameter STANDBY_CYC = `STANDBY_IDLE_CYC,
   parameter SLEEP_CYC   = `SLEEP_IDLE_CYC
)
(
   input  wire       ref_clk,
   input  wire       rstn,
   input  wire       supply_good,
   input  wire       supply_fail,
   input  wire       pwm_cmd,
   output reg        gate_drive,
   output reg        sense_enable,
   output reg        sense_power,
   output reg        core_power,
   output reg  [1:0] mode
);
   localparam [`TIMER_W-1:0] STBY_LIM = STANDBY_CYC[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] SLP_LIM  = SLEEP_CYC[`TIMER_W-1:0];

   reg        cmd_d_r;
   reg        armed_r;
   reg  [1:0] mode_nxt;
   reg        gate_nxt;
   reg        sense_en_nxt;
   reg        sense_pwr_nxt;
   reg        core_pwr_nxt;
   wire       supply_ok;
   wire       in_normal;
   wire       in_standby;
   wire       rise;
   wire       stby_exp;
   wire       slp_exp;

   // ======================================================
   // supply qualification
   // fail outranks good when both comparators are high
   // armed one edge after the supply is seen good
   assign supply_ok = supply_good && !supply_fail;

   // lockout waits for this flag as well as the level
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         armed_r <= 1'b0;
      end
      else
      begin
         // supply must be good before lockout may be left
         armed_r <= supply_ok;                     // R1
      end
   end

   // ======================================================
   // command edge detection
   // the pin idles low, so a low reset value gives no false
   // edge when reset is released
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_d_r <= 1'b0;
      end
      else
      begin
         cmd_d_r <= pwm_cmd;
      end
   end

   assign rise = pwm_cmd && !cmd_d_r;

   // ======================================================
   // current mode decode
   assign in_normal  = (mode == `MODE_NORMAL);
   assign in_standby = (mode == `MODE_STANDBY);

   // ======================================================
   // idle timers
   // a high command clears both, so only an unbroken low counts
   // the sleep timer starts at standby entry, after the standby one
   // both limits must fit the timer width
   idle_timer #(.W(`TIMER_W)) u_stby
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .clear   (pwm_cmd),                        // R14
      .run     (in_normal),                      // R7
      .limit   (STBY_LIM),
      .expired (stby_exp)
   );

   idle_timer #(.W(`TIMER_W)) u_slp
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .clear   (pwm_cmd),                        // R14
      .run     (in_standby),                     // R15
      .limit   (SLP_LIM),
      .expired (slp_exp)
   );

   // ======================================================
   // mode state machine
   // wake needs a rising edge, a level alone does not wake
   always @*
   begin
      // hold the mode unless a transition below fires
      mode_nxt = mode;
      case (mode)
         `MODE_LOCKOUT:
         begin
            // leave only once armed and commanded high
            if (armed_r && supply_ok && pwm_cmd)
            begin
               mode_nxt = `MODE_NORMAL;            // R3
            end
         end
         `MODE_NORMAL:
         begin
            // an unbroken low interval drops to standby
            if (stby_exp && !pwm_cmd)
            begin
               mode_nxt = `MODE_STANDBY;           // R7
            end
         end
         `MODE_STANDBY:
         begin
            // wake takes priority over the sleep timeout
            if (rise)
            begin
               mode_nxt = `MODE_NORMAL;            // R11
            end
            else if (slp_exp && !pwm_cmd)
            begin
               mode_nxt = `MODE_SLEEP;             // R9
            end
         end
         `MODE_SLEEP:
         begin
            // one cycle wake, inside both wake bounds
            if (rise)
            begin
               mode_nxt = `MODE_NORMAL;            // R11
            end
         end
         default:
         begin
            // unused code falls back to lockout
            mode_nxt = `MODE_LOCKOUT;
         end
      endcase
      // supply fail overrides every other transition
      if (supply_fail)
      begin
         mode_nxt = `MODE_LOCKOUT;                 // R4
      end
   end

   // ======================================================
   // mode register
   // binary codes, lockout is zero
   // a reset anywhere returns to lockout
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode <= `MODE_LOCKOUT;                    // R1
      end
      else
      begin
         mode <= mode_nxt;
      end
   end

   // ======================================================
   // output decode
   // decoded from the next mode so outputs change on the same
   // edge as the mode register
   always @*
   begin
      // defaults keep every output off
      gate_nxt      = 1'b0;
      sense_en_nxt  = 1'b0;
      sense_pwr_nxt = 1'b0;
      core_pwr_nxt  = 1'b0;
      case (mode_nxt)
         `MODE_NORMAL:
         begin
            // drive and sense follow the command
            gate_nxt      = pwm_cmd;               // R5
            sense_en_nxt  = pwm_cmd;               // R6
            sense_pwr_nxt = 1'b1;
            core_pwr_nxt  = 1'b1;
         end
         `MODE_STANDBY:
         begin
            // drive and current sense off, core kept up
            gate_nxt      = 1'b0;                  // R8
            sense_en_nxt  = 1'b0;
            sense_pwr_nxt = 1'b0;                  // R8
            core_pwr_nxt  = 1'b1;
         end
         `MODE_SLEEP:
         begin
            // everything off
            gate_nxt      = 1'b0;                  // R10
            sense_en_nxt  = 1'b0;
            sense_pwr_nxt = 1'b0;
            core_pwr_nxt  = 1'b0;                  // R10
         end
         `MODE_LOCKOUT:
         begin
            // command ignored, all functions held off
            gate_nxt      = 1'b0;                  // R2
            sense_en_nxt  = 1'b0;
            sense_pwr_nxt = 1'b0;
            core_pwr_nxt  = 1'b0;                  // R1
         end
         default:
         begin
            // unused code, all off
            gate_nxt      = 1'b0;
            sense_en_nxt  = 1'b0;
            sense_pwr_nxt = 1'b0;
            core_pwr_nxt  = 1'b0;
         end
      endcase
   end

   // ======================================================
   // output registers
   // gate drive
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gate_drive <= 1'b0;
      end
      else
      begin
         gate_drive <= gate_nxt;
      end
   end

   // sense output enable
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sense_enable <= 1'b0;
      end
      else
      begin
         sense_enable <= sense_en_nxt;
      end
   end

   // current-sense circuitry power
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sense_power <= 1'b0;
      end
      else
      begin
         sense_power <= sense_pwr_nxt;
      end
   end

   // remaining internal functions power
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         core_power <= 1'b0;
      end
      else
      begin
         core_power <= core_pwr_nxt;
      end
   end
endmodule // mode_sequencer
`default_nettype wire

// ==== hdl/mode_seq_regs.vh ====
`ifndef MODE_SEQ_REGS_VH
`define MODE_SEQ_REGS_VH
// operating modes
`define MODE_LOCKOUT       2'h0
`define MODE_NORMAL        2'h1
`define MODE_STANDBY       2'h2
`define MODE_SLEEP         2'h3
// clock period in nanoseconds (200 MHz)
`define CLK_PERIOD_NS      5
// idle timeouts in their own units
`define STANDBY_IDLE_US    75
`define SLEEP_IDLE_MS      10
// longest wake delays in nanoseconds
`define WAKE_STANDBY_NS    200
`define WAKE_SLEEP_NS      1000
// timeouts in cycles
`define STANDBY_IDLE_CYC   ((`STANDBY_IDLE_US * 1000) / `CLK_PERIOD_NS)
`define SLEEP_IDLE_CYC     ((`SLEEP_IDLE_MS * 1000000) / `CLK_PERIOD_NS)
// wake settling cycles (longest time, rounded down)
`define WAKE_STANDBY_CYC   (`WAKE_STANDBY_NS / `CLK_PERIOD_NS)
`define WAKE_SLEEP_CYC     (`WAKE_SLEEP_NS / `CLK_PERIOD_NS)
`define TIMER_W            24
`endif

// ==== hdl/idle_timer.v ====
`timescale 1ns/10ps
`default_nettype none
// counts consecutive enabled cycles; expired is a level once limit reached
module idle_timer
#(
   parameter W = 24
)
(
   input  wire         ref_clk,
   input  wire         rstn,
   input  wire         clear,
   input  wire         run,
   input  wire [W-1:0] limit,
   output reg          expired
);
   reg [W-1:0] count_r;

   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_r <= {W{1'b0}};
         expired <= 1'b0;
      end
      else if (clear || !run)
      begin
         count_r <= {W{1'b0}};
         expired <= 1'b0;
      end
      else if (count_r + 1'b1 >= limit)
      begin
         expired <= 1'b1;
      end
      else
      begin
         count_r <= count_r + 1'b1;
      end
   end
endmodule // idle_timer
`default_nettype wire

// ==== tb/mode_seq_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module mode_seq_checker
#(
   parameter STANDBY_CYC = 10,
   parameter SLEEP_CYC   = 20
)
(
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       supply_fail,
   input wire logic       pwm_cmd,
   input wire logic       gate_drive,
   input wire logic       sense_enable,
   input wire logic       sense_power,
   input wire logic       core_power,
   input wire logic [1:0] mode
);
   localparam S = STANDBY_CYC;
   localparam L = S + SLEEP_CYC;
   int low_r;
   always @(posedge ref_clk or negedge rstn)
      if (!rstn)
         low_r <= 0;
      else
         low_r <= (pwm_cmd || mode == 2'h0) ? 0 : low_r + 1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_wk; mode[1] && pwm_cmd && !supply_fail; endsequence
   property p_lk; mode == 2'h0 |-> !gate_drive && !core_power; endproperty
   a_lk: assert property (p_lk) else $error("lockout");
   property p_fl; supply_fail |=> mode == 2'h0 && !gate_drive; endproperty
   a_fl: assert property (p_fl) else $error("fail");
   property p_fo; mode == 2'h1 && !supply_fail |=>
      gate_drive == $past(pwm_cmd); endproperty
   a_fo: assert property (p_fo) else $error("follow");
   property p_se; sense_enable == (gate_drive && mode == 2'h1); endproperty
   a_se: assert property (p_se) else $error("sense");
   property p_lp; mode[1] |-> !gate_drive && !sense_power &&
      core_power == !mode[0]; endproperty
   a_lp: assert property (p_lp) else $error("low power");
   property p_wk; s_wk |=> mode == 2'h1 && gate_drive; endproperty
   a_wk: assert property (p_wk) else $error("wake");
   property p_sb; $rose(mode == 2'h2) |-> low_r inside {[S:S+4]}; endproperty
   a_sb: assert property (p_sb) else $error("standby");
   property p_sl; $rose(mode == 2'h3) |-> low_r inside {[L:L+8]}; endproperty
   a_sl: assert property (p_sl) else $error("sleep");
endmodule // mode_seq_checker
bind mode_sequencer mode_seq_checker
   #(.STANDBY_CYC(STANDBY_CYC), .SLEEP_CYC(SLEEP_CYC)) mode_seq_checker_inst (.*);
`default_nettype wire

// ==== tb/pwm_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwm_ctrl_model
(
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic       lvl,
   input  wire logic [1:0] len,
   output wire logic       pwm_cmd
);
   logic [1:0] cnt_r = 2'h0;
   logic       pat_r = 1'b0;
   assign pwm_cmd = pat_r | lvl;
   always @(posedge ref_clk)
   begin
      cnt_r <= (cnt_r == 2'h0) ? len : cnt_r - 2'h1;
      pat_r <= run && (pat_r ^ (cnt_r == 2'h0));
   end
endmodule // pwm_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) n_compared++; if ((a) !== (e)) begin bad_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end
module tb_top;
   localparam SB = 10;
   localparam SL = 20;
   logic       ref_clk = 1'b0, rstn = 1'b0, sg = 1'b0, sf = 1'b0;
   logic       run = 1'b0, lvl = 1'b0;
   logic [1:0] len = 2'h0;
   logic [5:0] exp_q[$], e;
   wire        pwm, gd, se, sp, cp;
   wire  [1:0] md;
   int         bad_count = 0, n_compared = 0;
   always #2.5 ref_clk = ~ref_clk;
   pwm_ctrl_model pwm_ctrl_model_inst (.ref_clk(ref_clk), .run(run),
      .lvl(lvl), .len(len), .pwm_cmd(pwm));
   mode_sequencer #(.STANDBY_CYC(SB), .SLEEP_CYC(SL)) mode_sequencer_inst
      (.ref_clk(ref_clk), .rstn(rstn), .supply_good(sg), .supply_fail(sf),
      .pwm_cmd(pwm), .gate_drive(gd), .sense_enable(se), .sense_power(sp),
      .core_power(cp), .mode(md));
   // x of 3f notes nothing
   task drv(input logic g, f, l, input logic [5:0] x);
      @(negedge ref_clk);
      sg = g;
      sf = f;
      lvl = l;
      if (x != 6'h3f)
         exp_q.push_back(x);
   endtask
   task finish_test;
      $display("mismatches %0d of %0d", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      #1;
      if (exp_q.size() != 0)
      begin
         e = exp_q.pop_front();
         `CHK({md, gd, se, sp, cp}, e)
      end
   end
   initial
   begin
      #5000;
      bad_count++;
      finish_test;
   end
   initial
   begin
      void'($urandom(32'h3b58));
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      drv(0, 0, 1, 6'h00);
      drv(1, 0, 1, 6'h3f);
      drv(1, 0, 1, 6'h1f);
      run = 1'b1;
      drv(1, 0, 0, 6'h3f);
      repeat (40)
      begin
         @(negedge ref_clk);
         len = 2'($urandom);
         exp_q.push_back(pwm ? 6'h1f : 6'h13);
      end
      drv(1, 0, 1, 6'h1f);
      run = 1'b0;
      repeat (SB - 1) drv(1, 0, 0, 6'h13);
      repeat (6) drv(1, 0, 0, 6'h3f);
      repeat (SL - 6) drv(1, 0, 0, 6'h21);
      repeat (12) drv(1, 0, 0, 6'h3f);
      drv(1, 0, 0, 6'h30);
      drv(1, 0, 1, 6'h1f);
      repeat (SB + 6) drv(1, 0, 0, 6'h3f);
      drv(1, 0, 1, 6'h1f);
      drv(1, 1, 1, 6'h00);
      drv(0, 0, 1, 6'h00);
      drv(0, 0, 0, 6'h3f);
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
